// [inc/rxeb_pkg.sv]
// Purpose: shared constants for the receive elastic bit buffer
// Assumes: AHB-Lite register window, 32-bit words at aligned byte offsets
// Notes: delay time is ms in Q16.8, data rate is bits per ms in Q13.11
package rxeb_pkg;
  // buffer geometry
  localparam int PTR_W = 18;
  localparam int DLY_W = 17;
  localparam logic [16:0] DLY_MIN = 17'h0_0004;
  localparam logic [16:0] DLY_MAX = 17'h1_FFFE;
  // reset values
  localparam logic [16:0] DLY_BITS_RST = 17'h0_0400;
  localparam logic [23:0] DLY_TIME_RST = 24'h00_0100;
  localparam logic [23:0] RATE_RST = 24'h20_0000;
  localparam logic [31:0] NCO_INC_RST = 32'h0218_DEF4;
  // fixed point: time Q.8 times rate Q.11 gives bits after this shift
  localparam int PROD_SHIFT = 19;
  localparam logic [6:0] PCT_SCALE = 7'h64;
  // divider shape
  localparam int DIV_NW = 40;
  localparam int DIV_DW = 24;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_DBITS = 8'h04;
  localparam logic [7:0] OFF_DTIME = 8'h08;
  localparam logic [7:0] OFF_RATE = 8'h0C;
  localparam logic [7:0] OFF_CMD = 8'h10;
  localparam logic [7:0] OFF_STAT = 8'h14;
  localparam logic [7:0] OFF_ISTAT = 8'h18;
  localparam logic [7:0] OFF_IMASK = 8'h1C;
  localparam logic [7:0] OFF_FILL = 8'h20;
  localparam logic [7:0] OFF_NCO = 8'h24;
  // field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_SEL_LSB = 1;
  localparam int CTRL_MODE_BIT = 3;
  localparam int CMD_RECEN_BIT = 0;
  localparam int CMD_CLRSLIP_BIT = 1;
  localparam int STAT_SLIP_BIT = 0;
  localparam int STAT_RUN_BIT = 1;
  localparam int STAT_BYP_BIT = 2;
  localparam int STAT_OCC_LSB = 8;
  localparam int INT_OVR_BIT = 0;
  localparam int INT_UDR_BIT = 1;
  localparam int INT_W = 2;
  // synchronised pin positions
  localparam int PIN_RXC = 0;
  localparam int PIN_RXD = 1;
  localparam int PIN_EXTC = 2;
  localparam int PIN_MODC = 3;
  // output clock sources
  typedef enum logic [1:0] {
    SEL_RX = 2'h0,
    SEL_NCO = 2'h1,
    SEL_EXT = 2'h2,
    SEL_MOD = 2'h3
  } rxeb_sel_t;
endpackage

// [hw/rxeb_sdiv.sv]
// Purpose: free-running restoring divider, one quotient bit per clock
// Assumes: operands are stable while a division runs, or the answer is stale
// Notes: a zero divisor gives an all-ones quotient
module rxeb_sdiv #(
  parameter int NW = rxeb_pkg::DIV_NW,
  parameter int DW = rxeb_pkg::DIV_DW
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_start,
  input wire logic [NW-1:0] i_num,
  input wire logic [DW-1:0] i_den,
  output logic [NW-1:0] o_quo,
  output logic o_done
);
  if (NW < 2 || NW > 255 || DW < 1) begin : g_bad_width
    $error("divider widths out of range");
  end

  logic [DW:0] rem_ff;
  logic [NW-1:0] quo_ff;
  logic [DW-1:0] den_ff;
  logic [7:0] cnt_ff;
  logic busy_ff;
  logic done_ff;
  logic [DW:0] trial;
  logic fits;

  // shift next dividend bit into the partial remainder
  assign trial = {rem_ff[DW-1:0], quo_ff[NW-1]};
  assign fits = trial >= {1'b0, den_ff};

  // load on start, then one step per clock; done pulses one cycle
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rem_ff <= '0;
      quo_ff <= '0;
      den_ff <= '0;
      cnt_ff <= 8'h00;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else if (!busy_ff) begin
      done_ff <= 1'b0;
      if (i_start) begin
        rem_ff <= '0;
        quo_ff <= i_num;
        den_ff <= i_den;
        cnt_ff <= 8'(NW);
        busy_ff <= 1'b1;
      end
    end else begin
      rem_ff <= fits ? trial - {1'b0, den_ff} : trial;
      quo_ff <= {quo_ff[NW-2:0], fits};
      cnt_ff <= cnt_ff - 8'h01;
      if (cnt_ff == 8'h01) begin
        busy_ff <= 1'b0;
        done_ff <= 1'b1;
      end
    end
  end

  assign o_quo = quo_ff;
  assign o_done = done_ff;
endmodule // rxeb_sdiv

// [hw/rxeb_core.sv]
// Purpose: bit-serial elastic receive buffer with selectable read clock
// Assumes: link clocks are far slower than i_clk; AHB-Lite slave, zero wait
// Notes: all link pins are sampled by i_clk; pointers pass through gray stages
module rxeb_core #(
  parameter int AW = rxeb_pkg::PTR_W,
  parameter logic [31:0] NCO_INC_DEF = rxeb_pkg::NCO_INC_RST
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  input wire logic i_rx_clk,
  input wire logic i_rx_data,
  input wire logic i_ext_clk,
  input wire logic i_mod_clk,
  output logic o_out_clk,
  output logic o_out_data,
  output logic o_slip,
  output logic o_irq
);
  localparam int DW = rxeb_pkg::DLY_W;
  if (AW < DW + 1) begin : g_bad_aw
    $error("pointer width cannot hold twice the largest delay");
  end

  typedef enum logic [2:0] {
    ST_OFF = 3'b001,
    ST_BYP = 3'b010,
    ST_RUN = 3'b100
  } rxeb_st_t;

  function automatic logic [AW-1:0] bin2gray(input logic [AW-1:0] b);
    return b ^ (b >> 1);
  endfunction

  function automatic logic [AW-1:0] gray2bin(input logic [AW-1:0] g);
    logic [AW-1:0] b;
    b = g;
    for (int i = AW - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  function automatic logic [DW-1:0] clamp_dly(input logic [28:0] v);
    if (v < 29'(rxeb_pkg::DLY_MIN)) begin
      return rxeb_pkg::DLY_MIN;
    end
    if (v > 29'(rxeb_pkg::DLY_MAX)) begin
      return rxeb_pkg::DLY_MAX;
    end
    return v[DW-1:0];
  endfunction

  // ---------------- bus slave ----------------
  logic dp_wr_ff;
  logic [7:0] dp_addr_ff;
  logic ahb_go;

  function automatic logic wr_hit(input logic [7:0] off);
    return dp_wr_ff && (dp_addr_ff == off);
  endfunction

  // capture address phase; only word transfers are expected so size is not checked
  assign ahb_go = i_hsel && i_htrans[1] && i_hready;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      dp_wr_ff <= 1'b0;
      dp_addr_ff <= 8'h00;
    end else if (i_hready) begin
      dp_wr_ff <= ahb_go && i_hwrite;
      dp_addr_ff <= {i_haddr[7:2], 2'b00};
    end
  end
  assign o_hreadyout = 1'b1; // never stalls
  assign o_hresp = 1'b0;

  // software settings
  logic en_ff;
  logic mode_time_ff;
  rxeb_pkg::rxeb_sel_t sel_ff;
  logic [DW-1:0] dly_bits_ff;
  logic [23:0] dly_time_ff;
  logic [23:0] rate_ff;
  logic [31:0] nco_inc_ff;
  logic [rxeb_pkg::INT_W-1:0] int_mask_ff;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      en_ff <= 1'b0;
      mode_time_ff <= 1'b0;
      sel_ff <= rxeb_pkg::SEL_RX;
      dly_bits_ff <= rxeb_pkg::DLY_BITS_RST;
      dly_time_ff <= rxeb_pkg::DLY_TIME_RST;
      rate_ff <= rxeb_pkg::RATE_RST;
      nco_inc_ff <= NCO_INC_DEF;
      int_mask_ff <= '0;
    end else begin
      if (wr_hit(rxeb_pkg::OFF_CTRL)) begin
        en_ff <= i_hwdata[rxeb_pkg::CTRL_EN_BIT];
        sel_ff <= rxeb_pkg::rxeb_sel_t'(i_hwdata[rxeb_pkg::CTRL_SEL_LSB +: 2]);
        mode_time_ff <= i_hwdata[rxeb_pkg::CTRL_MODE_BIT];
      end
      if (wr_hit(rxeb_pkg::OFF_DBITS)) begin
        dly_bits_ff <= i_hwdata[DW-1:0];
      end
      if (wr_hit(rxeb_pkg::OFF_DTIME)) begin
        dly_time_ff <= i_hwdata[23:0];
      end
      if (wr_hit(rxeb_pkg::OFF_RATE)) begin
        rate_ff <= i_hwdata[23:0];
      end
      if (wr_hit(rxeb_pkg::OFF_NCO)) begin
        nco_inc_ff <= i_hwdata;
      end
      if (wr_hit(rxeb_pkg::OFF_IMASK)) begin
        int_mask_ff <= i_hwdata[rxeb_pkg::INT_W-1:0];
      end
    end
  end

  // command strobes
  logic cmd_recen;
  logic slip_clr;
  assign cmd_recen = wr_hit(rxeb_pkg::OFF_CMD) && i_hwdata[rxeb_pkg::CMD_RECEN_BIT];
  assign slip_clr = (wr_hit(rxeb_pkg::OFF_CMD) && i_hwdata[rxeb_pkg::CMD_CLRSLIP_BIT]) ||
                    wr_hit(rxeb_pkg::OFF_DBITS) || wr_hit(rxeb_pkg::OFF_DTIME);

  // ---------------- effective delay ----------------
  logic [47:0] prod;
  logic [DW-1:0] nxt_eff_bits;
  logic [DW-1:0] eff_bits_ff;
  logic dly_chg;
  logic [DW-1:0] eff_prev_ff;
  assign prod = dly_time_ff * rate_ff;
  assign nxt_eff_bits = mode_time_ff ? clamp_dly(prod[47:rxeb_pkg::PROD_SHIFT]) : clamp_dly(29'(dly_bits_ff));
  // flagged a cycle late, so the recenter already sees the new center
  assign dly_chg = eff_bits_ff != eff_prev_ff;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      eff_bits_ff <= rxeb_pkg::DLY_BITS_RST;
      eff_prev_ff <= rxeb_pkg::DLY_BITS_RST;
    end else begin
      eff_bits_ff <= nxt_eff_bits;
      eff_prev_ff <= eff_bits_ff;
    end
  end

  // ---------------- pin sampling ----------------
  logic [3:0] pins;
  logic [3:0] pin_s1_ff;
  logic [3:0] pin_s2_ff;
  logic [3:0] pin_s3_ff;
  logic [3:0] pin_rise;
  assign pins = {i_mod_clk, i_ext_clk, i_rx_data, i_rx_clk};
  // two flops before use; third flop only for edge finding
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pin_s1_ff <= 4'h0;
      pin_s2_ff <= 4'h0;
      pin_s3_ff <= 4'h0;
    end else begin
      pin_s1_ff <= pins;
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
    end
  end
  assign pin_rise = pin_s2_ff & ~pin_s3_ff;

  // ---------------- operating state ----------------
  rxeb_st_t st_ff;
  rxeb_st_t nxt_st;
  always_comb begin
    case ({en_ff, sel_ff == rxeb_pkg::SEL_RX})
      2'b10: nxt_st = ST_RUN;
      2'b11: nxt_st = ST_BYP;
      default: nxt_st = ST_OFF;
    endcase
  end
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_ff <= ST_OFF;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ---------------- read clock ----------------
  logic [31:0] nco_ff;
  logic rd_lvl;
  logic rd_lvl_d_ff;
  logic rd_stb;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      nco_ff <= 32'h0000_0000;
    end else begin
      nco_ff <= nco_ff + nco_inc_ff;
    end
  end
  // source select; external source relies on the station rate
  always_comb begin
    case (sel_ff)
      rxeb_pkg::SEL_RX: rd_lvl = pin_s2_ff[rxeb_pkg::PIN_RXC];
      rxeb_pkg::SEL_NCO: rd_lvl = nco_ff[31];
      rxeb_pkg::SEL_EXT: rd_lvl = pin_s2_ff[rxeb_pkg::PIN_EXTC];
      rxeb_pkg::SEL_MOD: rd_lvl = pin_s2_ff[rxeb_pkg::PIN_MODC];
      default: rd_lvl = 1'b0;
    endcase
  end
  // a source switch may yield one extra read edge; traffic slips anyway on reselect
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rd_lvl_d_ff <= 1'b0;
    end else begin
      rd_lvl_d_ff <= rd_lvl;
    end
  end
  assign rd_stb = rd_lvl && !rd_lvl_d_ff && (st_ff == ST_RUN);

  // ---------------- pointers ----------------
  logic mem [0:(1 << AW) - 1];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW-1:0] wr_g_ff, wr_g_s1_ff, wr_g_s2_ff;
  logic [AW-1:0] rd_g_ff, rd_g_s1_ff, rd_g_s2_ff;
  logic [AW-1:0] wr_view;
  logic [AW-1:0] rd_view;
  logic [AW-1:0] occ_w;
  logic [AW-1:0] occ_r;
  logic [AW-1:0] center;
  logic [AW-1:0] dbl;
  logic wr_stb;
  logic recen;
  logic ovr_ev;
  logic udr_ev;

  // gray pointers, two stages each way
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wr_g_ff <= '0;
      wr_g_s1_ff <= '0;
      wr_g_s2_ff <= '0;
      rd_g_ff <= '0;
      rd_g_s1_ff <= '0;
      rd_g_s2_ff <= '0;
    end else begin
      wr_g_ff <= bin2gray(wr_ptr_ff);
      wr_g_s1_ff <= wr_g_ff;
      wr_g_s2_ff <= wr_g_s1_ff;
      rd_g_ff <= bin2gray(rd_ptr_ff);
      rd_g_s1_ff <= rd_g_ff;
      rd_g_s2_ff <= rd_g_s1_ff;
    end
  end
  assign wr_view = gray2bin(wr_g_s2_ff);
  assign rd_view = gray2bin(rd_g_s2_ff);

  // stale views only make overrun and under-run fire a little early, never late
  assign center = AW'(eff_bits_ff);
  assign dbl = AW'({eff_bits_ff, 1'b0});
  assign occ_w = wr_ptr_ff - rd_view;
  assign occ_r = wr_view - rd_ptr_ff;
  assign wr_stb = pin_rise[rxeb_pkg::PIN_RXC] && (st_ff == ST_RUN);
  // held at center while idle, on command, on delay change
  assign recen = cmd_recen || dly_chg || (st_ff != ST_RUN);
  assign ovr_ev = wr_stb && (occ_w + AW'(1) >= dbl);
  assign udr_ev = rd_stb && (occ_r <= AW'(1)) && !recen;

  // bit store; no reset, contents are traffic
  always_ff @(posedge i_clk) begin
    if (wr_stb) begin
      mem[wr_ptr_ff] <= pin_s2_ff[rxeb_pkg::PIN_RXD];
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wr_ptr_ff <= '0;
    end else if (ovr_ev) begin
      wr_ptr_ff <= rd_view + center;
    end else if (wr_stb) begin
      wr_ptr_ff <= wr_ptr_ff + AW'(1);
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rd_ptr_ff <= '0;
    end else if (recen || udr_ev) begin
      rd_ptr_ff <= wr_view - center;
    end else if (rd_stb) begin
      rd_ptr_ff <= rd_ptr_ff + AW'(1);
    end
  end

  // ---------------- outputs to the data interface ----------------
  logic out_clk_ff;
  logic out_data_ff;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      out_clk_ff <= 1'b0;
      out_data_ff <= 1'b0;
    end else begin
      out_clk_ff <= (st_ff == ST_OFF) ? 1'b0 : rd_lvl;
      if (st_ff == ST_BYP && pin_rise[rxeb_pkg::PIN_RXC]) begin
        out_data_ff <= pin_s2_ff[rxeb_pkg::PIN_RXD];
      end else if (rd_stb) begin
        out_data_ff <= mem[rd_ptr_ff];
      end
    end
  end
  assign o_out_clk = out_clk_ff;
  assign o_out_data = out_data_ff;

  // ---------------- slip, interrupts ----------------
  logic slip_ff;
  logic [rxeb_pkg::INT_W-1:0] int_stat_ff;
  logic [rxeb_pkg::INT_W-1:0] int_set;
  logic [rxeb_pkg::INT_W-1:0] int_clr;
  logic irq_ff;
  assign int_set = {udr_ev, ovr_ev};
  assign int_clr = wr_hit(rxeb_pkg::OFF_ISTAT) ? i_hwdata[rxeb_pkg::INT_W-1:0] : '0;
  // latched slip; a new slip wins over a clear
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      slip_ff <= 1'b0;
      int_stat_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      slip_ff <= ovr_ev || udr_ev || (slip_ff && !slip_clr);
      int_stat_ff <= int_set | (int_stat_ff & ~int_clr);
      irq_ff <= |(int_stat_ff & int_mask_ff);
    end
  end
  assign o_slip = slip_ff;
  assign o_irq = irq_ff;

  // ---------------- fill percent and derived time ----------------
  logic [rxeb_pkg::DIV_NW-1:0] pct_q;
  logic [rxeb_pkg::DIV_NW-1:0] tim_q;
  logic pct_done;
  logic tim_done;
  logic [15:0] pct_ff;
  logic [23:0] dtime_ff;
  logic [15:0] fill_rpt;

  rxeb_sdiv #(.NW(rxeb_pkg::DIV_NW), .DW(rxeb_pkg::DIV_DW)) u_pct_div (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_start(1'b1),
    .i_num(rxeb_pkg::DIV_NW'(occ_r) * rxeb_pkg::DIV_NW'(rxeb_pkg::PCT_SCALE)),
    .i_den(rxeb_pkg::DIV_DW'(eff_bits_ff)),
    .o_quo(pct_q),
    .o_done(pct_done)
  );
  rxeb_sdiv #(.NW(rxeb_pkg::DIV_NW), .DW(rxeb_pkg::DIV_DW)) u_tim_div (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_start(1'b1),
    .i_num(rxeb_pkg::DIV_NW'(eff_bits_ff) << rxeb_pkg::PROD_SHIFT),
    .i_den(rate_ff),
    .o_quo(tim_q),
    .o_done(tim_done)
  );
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pct_ff <= 16'h0000;
      dtime_ff <= rxeb_pkg::DLY_TIME_RST; // matches the reset delay until the first division lands
    end else begin
      if (pct_done) begin
        pct_ff <= pct_q[15:0];
      end
      if (tim_done) begin
        dtime_ff <= tim_q[23:0];
      end
    end
  end
  assign fill_rpt = slip_ff ? 16'h0000 - pct_ff : pct_ff;

  // register read mux, unmapped words read zero
  always_comb begin
    o_hrdata = 32'h0000_0000;
    case (dp_addr_ff)
      rxeb_pkg::OFF_CTRL: begin
        o_hrdata[rxeb_pkg::CTRL_EN_BIT] = en_ff;
        o_hrdata[rxeb_pkg::CTRL_SEL_LSB +: 2] = sel_ff;
        o_hrdata[rxeb_pkg::CTRL_MODE_BIT] = mode_time_ff;
      end
      rxeb_pkg::OFF_DBITS: o_hrdata[DW-1:0] = eff_bits_ff;
      rxeb_pkg::OFF_DTIME: o_hrdata[23:0] = mode_time_ff ? dly_time_ff : dtime_ff;
      rxeb_pkg::OFF_RATE: o_hrdata[23:0] = rate_ff;
      rxeb_pkg::OFF_STAT: begin
        o_hrdata[rxeb_pkg::STAT_SLIP_BIT] = slip_ff;
        o_hrdata[rxeb_pkg::STAT_RUN_BIT] = st_ff == ST_RUN;
        o_hrdata[rxeb_pkg::STAT_BYP_BIT] = st_ff == ST_BYP;
        o_hrdata[rxeb_pkg::STAT_OCC_LSB +: AW] = occ_r;
      end
      rxeb_pkg::OFF_ISTAT: o_hrdata[rxeb_pkg::INT_W-1:0] = int_stat_ff;
      rxeb_pkg::OFF_IMASK: o_hrdata[rxeb_pkg::INT_W-1:0] = int_mask_ff;
      rxeb_pkg::OFF_FILL: o_hrdata = {{16{fill_rpt[15]}}, fill_rpt};
      rxeb_pkg::OFF_NCO: o_hrdata = nco_inc_ff;
      default: o_hrdata = 32'h0000_0000;
    endcase
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  sequence s_overrun;
    wr_stb && (occ_w + AW'(1) >= dbl);
  endsequence
  sequence s_underrun;
    udr_ev;
  endsequence

  a_wr_rx_only: assert property (!$stable(wr_ptr_ff) |-> $past(pin_rise[rxeb_pkg::PIN_RXC]))
    else $error("write pointer moved without a receive clock edge");
  a_bypass_data: assert property ((st_ff == ST_BYP) && pin_rise[rxeb_pkg::PIN_RXC]
    |=> (o_out_data == $past(pin_s2_ff[rxeb_pkg::PIN_RXD])) && o_out_clk)
    else $error("bypass did not pass receive data");
  a_mod_clock: assert property ((st_ff == ST_RUN) && (sel_ff == rxeb_pkg::SEL_MOD)
    && pin_rise[rxeb_pkg::PIN_MODC] |=> o_out_clk)
    else $error("output clock did not follow modulator clock");
  a_delay_range: assert property (eff_bits_ff >= rxeb_pkg::DLY_MIN && eff_bits_ff <= rxeb_pkg::DLY_MAX)
    else $error("effective delay outside range");
  a_occ_bound: assert property (wr_stb |=> occ_w < dbl)
    else $error("occupancy reached twice the delay");
  a_ovr_center: assert property (s_overrun |=> (occ_w == $past(center)) || !$stable(rd_view))
    else $error("overrun did not return to center");
  a_udr_center: assert property (s_underrun |=> (occ_r == $past(center)) || !$stable(wr_view))
    else $error("under-run did not return to center");
  a_slip_hold: assert property (slip_ff && !slip_clr |=> slip_ff ##1 slip_ff || $past(slip_clr))
    else $error("slip flag dropped without a clear");
  a_slip_set: assert property ((ovr_ev || udr_ev) |=> o_slip ##1 o_slip || $past(slip_clr))
    else $error("slip flag not set by a slip");
  a_fill_neg: assert property (slip_ff && pct_ff != 16'h0000 |-> fill_rpt[15])
    else $error("fill not negative while slipped");
  a_slip_clear: assert property (slip_clr && !ovr_ev && !udr_ev |=> !o_slip)
    else $error("slip flag survived a clear");
  a_recen_cmd: assert property (cmd_recen && (st_ff == ST_RUN) |=> (occ_r == $past(center))
    || !$stable(wr_view))
    else $error("recenter command did not restore center");
endmodule // rxeb_core

// [tb/rxeb_link_model.sv]
// Purpose: far-side link model, receive bit stream plus station clocks
// Assumes: link bit period 80 ns, link clocks stop low between frames
// Notes: data keeps changing while idle so a stale bit never looks valid
module rxeb_link_model (
  input wire logic i_run,
  output logic o_rx_clk,
  output logic o_rx_data,
  output logic o_ext_clk,
  output logic o_mod_clk,
  output logic o_last_bit
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] seed;
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  // receive clock halts low; data moves on falling slots and on every idle slot
  initial begin
    seed = 32'h0000_0025;
    o_rx_clk = 1'b0;
    o_rx_data = 1'b0;
    o_last_bit = 1'b0;
    forever begin
      #40;
      if (i_run || o_rx_clk) o_rx_clk = ~o_rx_clk;
      if (o_rx_clk) o_last_bit = o_rx_data;
      else begin
        seed = xs(seed);
        o_rx_data = seed[0];
      end
    end
  end
  initial begin
    o_ext_clk = 1'b0;
    o_mod_clk = 1'b0;
    #13;
    forever begin
      #40;
      if (i_run || o_ext_clk) o_ext_clk = ~o_ext_clk;
      o_mod_clk = o_ext_clk;
    end
  end
endmodule // rxeb_link_model

// [tb/testbench.sv]
// Purpose: self-checking bench for the receive elastic bit buffer
// Assumes: zero-wait bus slave, link at 80 ns per bit
// Notes: random delay times come from an xorshift seeded at 37
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rstn, hsel, hwrite, hrdy, hresp, run, byp, rx_clk, rx_data, ext_clk, mod_clk, last_bit;
  logic out_clk, out_data, slip, irq;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, rv, s, edges;
  logic [23:0] t, r;
  int err_total, checks_done, cyc;
  logic [7:0] offs [9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h18, 8'h1C, 8'h24, 8'h28};
  logic [31:0] rstv [9] = '{32'h0, 32'h400, 32'h100, 32'h20_0000, 32'h0, 32'h0, 32'h0, 32'h0218_DEF4, 32'h0};
  rxeb_core DUT (.i_clk(clk), .i_rstn(rstn), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hrdy), .o_hreadyout(hrdy),
    .o_hresp(hresp), .o_hrdata(hrdata), .i_rx_clk(rx_clk), .i_rx_data(rx_data), .i_ext_clk(ext_clk),
    .i_mod_clk(mod_clk), .o_out_clk(out_clk), .o_out_data(out_data), .o_slip(slip), .o_irq(irq));
  rxeb_link_model LINK (.i_run(run), .o_rx_clk(rx_clk), .o_rx_data(rx_data), .o_ext_clk(ext_clk),
    .o_mod_clk(mod_clk), .o_last_bit(last_bit));
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  // bits held for a time at a rate, clamped to the legal span
  function automatic logic [31:0] exp_bits(input logic [23:0] tt, input logic [23:0] rr);
    logic [47:0] p;
    p = ({24'h0, tt} * {24'h0, rr}) >> rxeb_pkg::PROD_SHIFT;
    if (p < 48'h4) return 32'h4;
    if (p > 48'h1_FFFE) return 32'h1_FFFE;
    return p[31:0];
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // address phase held until ready, then data phase until ready again
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk); while (hrdy !== 1'b1 && ++n < 100);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hrdy !== 1'b1 && ++n < 200);
    rv = hrdata;
  endtask
  task automatic wait_slip();
    int n;
    n = 0;
    while (slip !== 1'b1 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 3000) err_total++;
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // hang guard, far above the few thousand cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_total++;
      give_verdict();
    end
  end
  always @(posedge out_clk) edges <= edges + 1;
  always @(negedge out_clk) if (byp) chk("bypass bit", {31'h0, out_data}, {31'h0, last_bit});
  initial begin
    {rstn, hsel, hwrite, run, byp, htrans, haddr, hwdata} = '0;
    {err_total, checks_done, cyc, edges} = '0;
    s = 32'h0000_0025;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    foreach (offs[i]) begin
      bus(0, offs[i], 0);
      chk("reset value", rv, rstv[i]);
    end
    foreach (rstv[i]) begin
      bus(1, 8'h04, i < 4 ? {30'h0, i[1:0]} : 32'h1_FFF8 + i);
      bus(0, 8'h04, 0);
      // bit 17 is not stored, so 0x20000 lands as zero and clamps up
      chk("delay clamp", rv, i < 4 || i == 8 ? 32'h4 : (i > 5 ? 32'h1_FFFE : 32'h1_FFF8 + i));
    end
    bus(1, 8'h00, 32'h8);
    repeat (6) begin
      s = xs(s);
      t = {9'h0, s[14:0]} | 24'h1;
      r = {4'h0, s[31:12]} | 24'h08_0000;
      bus(1, 8'h0C, {8'h0, r});
      bus(1, 8'h08, {8'h0, t});
      repeat (45) @(posedge clk);
      bus(0, 8'h04, 0);
      chk("bits from time", rv, exp_bits(t, r));
    end
    bus(1, 8'h0C, 32'h20_0000);
    bus(1, 8'h00, 32'h0);
    bus(1, 8'h04, 32'h400);
    bus(1, 8'h00, 32'h3);
    repeat (50) @(posedge clk);
    bus(0, 8'h20, 0);
    chk("fill at start", rv, 32'h64);
    bus(0, 8'h14, 0);
    chk("occupancy", rv, 32'h0004_0002);
    bus(1, 8'h24, 32'h1999_999A); // internal clock at the link rate
    for (int k = 1; k < 4; k++) begin
      bus(1, 8'h00, {28'h0, k[1:0], 1'b1});
      run <= 1'b1;
      repeat (300) @(posedge clk);
      chk("out clock runs", {31'h0, edges > 32'h4}, 32'h1);
      run <= 1'b0;
      edges <= '0;
      repeat (20) @(posedge clk);
    end
    bus(1, 8'h00, 32'h1);
    byp <= 1'b1;
    run <= 1'b1;
    repeat (400) @(posedge clk);
    bus(0, 8'h14, 0);
    chk("bypass status", rv & 32'h6, 32'h4);
    run <= 1'b0;
    byp <= 1'b0;
    repeat (20) @(posedge clk);
    // eight bits, a whole multiple of a tiny frame
    bus(1, 8'h1C, 32'h3);
    bus(1, 8'h04, 32'h8);
    bus(1, 8'h24, 32'h1000_0000);
    bus(1, 8'h00, 32'h3);
    run <= 1'b1;
    wait_slip();
    run <= 1'b0;
    bus(1, 8'h00, 32'h0);
    chk("overrun slip", {31'h0, slip}, 32'h1);
    chk("irq raised", {31'h0, irq}, 32'h1);
    bus(0, 8'h20, 0);
    chk("fill negative", {31'h0, rv[31]}, 32'h1);
    bus(0, 8'h18, 0);
    chk("overrun status", rv & 32'h1, 32'h1);
    bus(1, 8'h10, 32'h2);
    bus(1, 8'h18, 32'h3);
    bus(0, 8'h18, 0);
    chk("status cleared", rv, 32'h0);
    chk("slip cleared", {30'h0, irq, slip}, 32'h0);
    bus(1, 8'h24, 32'h3333_3333);
    bus(1, 8'h00, 32'h3);
    wait_slip();
    bus(1, 8'h00, 32'h0);
    bus(0, 8'h18, 0);
    chk("underrun status", rv & 32'h2, 32'h2);
    bus(1, 8'h04, 32'h400);
    @(posedge clk);
    chk("write clears slip", {31'h0, slip}, 32'h0);
    bus(1, 8'h24, 32'h0);
    bus(1, 8'h00, 32'h3);
    run <= 1'b1;
    repeat (250) @(posedge clk);
    run <= 1'b0;
    bus(1, 8'h10, 32'h1);
    repeat (10) @(posedge clk);
    bus(0, 8'h14, 0);
    chk("recenter", {31'h0, rv[25:8] >= 18'd1023 && rv[25:8] <= 18'd1025}, 32'h1);
    give_verdict();
  end
endmodule // testbench
